// ### audio_fifo_pkg.sv
package audio_fifo_pkg;

  // FIFO geometry
  localparam int unsigned DATA_W    = 32;
  localparam int unsigned DEPTH     = 64;
  localparam int unsigned PTR_W     = 6;
  localparam int unsigned CNT_W     = 7;
  localparam logic [6:0]  FIFO_FULL = 7'h40;
  localparam logic [6:0]  FIFO_NONE = 7'h00;

  // Register byte offsets
  localparam logic [3:0] RX_CTL_OFS = 4'h0;
  localparam logic [3:0] TX_CTL_OFS = 4'h4;
  localparam logic [3:0] STATUS_OFS = 4'h8;

  // Control register fields
  localparam int unsigned THR_LSB   = 8;
  localparam int unsigned THR_MSB   = 15;
  localparam int unsigned EN_BIT    = 16;
  localparam logic [31:0] CTL_RESET = 32'h0000_0000;

  // Status register fields
  localparam int unsigned ST_RX_OVF  = 0;
  localparam int unsigned ST_TX_UDF  = 1;
  localparam int unsigned ST_RX_EVT  = 2;
  localparam int unsigned ST_TX_EVT  = 3;
  localparam int unsigned ST_RX_LVL  = 8;
  localparam int unsigned ST_TX_LVL  = 16;

  // Avalon-MM request from the master
  typedef struct packed {
    logic        read;
    logic        write;
    logic [3:0]  address;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } avs_req_t;

  // One word with its strobe
  typedef struct packed {
    logic        valid;
    logic [31:0] data;
  } word_t;

endpackage : audio_fifo_pkg

// ### two_entry_buffer.sv
`timescale 1ns/100ps
module two_entry_buffer (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // Filling side
  input  wire logic        i_in_valid,
  input  wire logic [31:0] i_in_data,
  output logic             o_in_ready,
  // Draining side
  output logic             o_out_valid,
  output logic [31:0]      o_out_data,
  input  wire logic        i_out_ready
);

  logic [31:0] slot0_r, slot0_nxt;
  logic [31:0] slot1_r, slot1_nxt;
  logic [1:0]  cnt_r,   cnt_nxt;
  logic        push;
  logic        pop;

  assign o_in_ready  = (cnt_r != 2'h2);
  assign o_out_valid = (cnt_r != 2'h0);
  assign o_out_data  = slot0_r;
  assign push        = i_in_valid & o_in_ready;
  assign pop         = o_out_valid & i_out_ready;

  // Slot 0 is always the head, so the output is a plain flop
  always_comb begin
    slot0_nxt = slot0_r;
    slot1_nxt = slot1_r;
    cnt_nxt   = cnt_r;
    if (pop) begin
      slot0_nxt = slot1_r;
      cnt_nxt   = cnt_nxt - 2'h1;
    end
    if (push) begin
      if (cnt_nxt == 2'h0) begin
        slot0_nxt = i_in_data;
      end else begin
        slot1_nxt = i_in_data;
      end
      cnt_nxt = cnt_nxt + 2'h1;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      slot0_r <= 32'h0000_0000;
      slot1_r <= 32'h0000_0000;
      cnt_r   <= 2'h0;
    end else begin
      slot0_r <= slot0_nxt;
      slot1_r <= slot1_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

endmodule : two_entry_buffer

// ### audio_port_fifo_dma_event.sv
// Contract
// [RULE1] Raise a DMA event each time threshold words move on the pin side.
// [RULE2] Retire a pending event once the DMA moves threshold words.
// [RULE3] Threshold comes from bits 15:8 of each FIFO control register.
// [RULE4] Each FIFO holds 64 words; full and empty limits use that depth.
// [RULE5] A set coinciding with a clear keeps the event asserted.
// [RULE6] Flag receive overflow and transmit underflow until software clears.
// [RULE7] Software should pick thresholds as serializer multiples up to 32.
// [RULE8] The DMA should service audio requests with low latency.
// [RULE9] Each event is a level held until retired.
`timescale 1ns/100ps
module audio_port_fifo_dma_event (
  // Clock and reset
  input  wire logic                      i_clk,
  input  wire logic                      i_rst,
  // Avalon-MM register slave
  input  wire audio_fifo_pkg::avs_req_t  i_avs,
  output logic [31:0]                    o_avs_readdata,
  output logic                           o_avs_waitrequest,
  // Receive pin side
  input  wire audio_fifo_pkg::word_t     i_rx_pin,
  // Receive DMA side
  output logic                           o_rx_dma_valid,
  output logic [31:0]                    o_rx_dma_data,
  input  wire logic                      i_rx_dma_ready,
  output logic                           o_rx_dma_event,
  // Transmit DMA side
  input  wire audio_fifo_pkg::word_t     i_tx_dma,
  output logic                           o_tx_dma_ready,
  output logic                           o_tx_dma_event,
  // Transmit pin side
  input  wire logic                      i_tx_pin_pull,
  output logic [31:0]                    o_tx_pin_data,
  output logic                           o_tx_pin_valid
);

  ////////////////////////////////////////////////////////////////////////////
  // Shared arithmetic

  // Word counter toward threshold; bit 8 flags the hit, zero disables
  function automatic logic [8:0] thr_step(input logic [7:0] cnt,
                                          input logic       inc,
                                          input logic [7:0] thr);
    logic [8:0] res;
    res = {1'b0, cnt};
    if (inc && (thr != 8'h00)) begin
      if ((cnt + 8'h01) >= thr) begin
        res = {1'b1, 8'h00};
      end else begin
        res = {1'b0, cnt + 8'h01};
      end
    end
    return res;
  endfunction : thr_step

  // Pending events; a clear against a set cancels out, but with none pending the set counts; never drops
  function automatic logic [7:0] pend_step(input logic [7:0] p,
                                           input logic       set,
                                           input logic       clr);
    logic [7:0] res;
    res = p;
    if (set && !(clr && (p != 8'h00))) begin
      res = p + 8'h01;
    end else if (!set && clr && (p != 8'h00)) begin
      res = p - 8'h01;
    end
    return res;
  endfunction : pend_step

  function automatic logic [31:0] merge_be(input logic [31:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0]  be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge_be

  ////////////////////////////////////////////////////////////////////////////
  // Register bus

  logic        ack_r,    ack_nxt;
  logic [31:0] rdata_r,  rdata_nxt;
  logic [31:0] rx_ctl_r, rx_ctl_nxt;
  logic [31:0] tx_ctl_r, tx_ctl_nxt;
  logic        rx_ovf_r, rx_ovf_nxt;
  logic        tx_udf_r, tx_udf_nxt;
  logic        wr_ok;
  logic        tx_start;
  logic [7:0]  rx_thr;
  logic [7:0]  tx_thr;
  logic        rx_overflow;
  logic        tx_underflow;
  logic [6:0]  rx_cnt_r;
  logic [6:0]  tx_cnt_r;

  assign rx_thr            = rx_ctl_r[audio_fifo_pkg::THR_MSB:
                                      audio_fifo_pkg::THR_LSB];  // [RULE3]
  assign tx_thr            = tx_ctl_r[audio_fifo_pkg::THR_MSB:
                                      audio_fifo_pkg::THR_LSB];  // [RULE3]
  assign o_avs_waitrequest = (i_avs.read | i_avs.write) & ~ack_r;
  assign o_avs_readdata    = rdata_r;
  assign wr_ok             = i_avs.write & ack_r;
  assign tx_start          = tx_ctl_nxt[audio_fifo_pkg::EN_BIT] &
                             ~tx_ctl_r[audio_fifo_pkg::EN_BIT];

  always_comb begin
    ack_nxt    = (i_avs.read | i_avs.write) & ~ack_r;
    rdata_nxt  = rdata_r;
    rx_ctl_nxt = rx_ctl_r;
    tx_ctl_nxt = tx_ctl_r;
    rx_ovf_nxt = rx_ovf_r;
    tx_udf_nxt = tx_udf_r;
    if (i_avs.read && !ack_r) begin
      case (i_avs.address)
        audio_fifo_pkg::RX_CTL_OFS: rdata_nxt = rx_ctl_r;
        audio_fifo_pkg::TX_CTL_OFS: rdata_nxt = tx_ctl_r;
        audio_fifo_pkg::STATUS_OFS: begin
          rdata_nxt = 32'h0000_0000;
          rdata_nxt[audio_fifo_pkg::ST_RX_OVF] = rx_ovf_r;
          rdata_nxt[audio_fifo_pkg::ST_TX_UDF] = tx_udf_r;
          rdata_nxt[audio_fifo_pkg::ST_RX_EVT] = o_rx_dma_event;
          rdata_nxt[audio_fifo_pkg::ST_TX_EVT] = o_tx_dma_event;
          rdata_nxt[audio_fifo_pkg::ST_RX_LVL +: 7] = rx_cnt_r;
          rdata_nxt[audio_fifo_pkg::ST_TX_LVL +: 7] = tx_cnt_r;
        end
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
    if (wr_ok) begin
      case (i_avs.address)
        audio_fifo_pkg::RX_CTL_OFS:
          rx_ctl_nxt = merge_be(rx_ctl_r, i_avs.writedata, i_avs.byteenable);
        audio_fifo_pkg::TX_CTL_OFS:
          tx_ctl_nxt = merge_be(tx_ctl_r, i_avs.writedata, i_avs.byteenable);
        audio_fifo_pkg::STATUS_OFS: begin
          if (i_avs.byteenable[0]) begin
            rx_ovf_nxt = rx_ovf_r &
                         ~i_avs.writedata[audio_fifo_pkg::ST_RX_OVF];
            tx_udf_nxt = tx_udf_r &
                         ~i_avs.writedata[audio_fifo_pkg::ST_TX_UDF];
          end
        end
        default: ;
      endcase
    end
    // Hardware set wins over the software clear
    if (rx_overflow) begin
      rx_ovf_nxt = 1'b1;  // [RULE6]
    end
    if (tx_underflow) begin
      tx_udf_nxt = 1'b1;  // [RULE6]
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ack_r    <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rx_ctl_r <= audio_fifo_pkg::CTL_RESET;
      tx_ctl_r <= audio_fifo_pkg::CTL_RESET;
      rx_ovf_r <= 1'b0;
      tx_udf_r <= 1'b0;
    end else begin
      ack_r    <= ack_nxt;
      rdata_r  <= rdata_nxt;
      rx_ctl_r <= rx_ctl_nxt;
      tx_ctl_r <= tx_ctl_nxt;
      rx_ovf_r <= rx_ovf_nxt;
      tx_udf_r <= tx_udf_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive FIFO

  logic [31:0] rx_mem_r [audio_fifo_pkg::DEPTH];
  logic [31:0] rx_mem_nxt [audio_fifo_pkg::DEPTH];
  logic [5:0]  rx_wp_r, rx_wp_nxt;
  logic [5:0]  rx_rp_r, rx_rp_nxt;
  logic [6:0]  rx_cnt_nxt;
  logic        rx_push;
  logic        rx_pop;
  logic        buf_in_ready;
  logic        rx_take;

  // Words arriving while full are lost and flagged
  assign rx_push     = i_rx_pin.valid & rx_ctl_r[audio_fifo_pkg::EN_BIT] &
                       (rx_cnt_r != audio_fifo_pkg::FIFO_FULL);  // [RULE4]
  assign rx_overflow = i_rx_pin.valid & rx_ctl_r[audio_fifo_pkg::EN_BIT] &
                       (rx_cnt_r == audio_fifo_pkg::FIFO_FULL);  // [RULE6]
  assign rx_pop      = (rx_cnt_r != audio_fifo_pkg::FIFO_NONE) & buf_in_ready;
  assign rx_take     = o_rx_dma_valid & i_rx_dma_ready;

  always_comb begin
    rx_mem_nxt = rx_mem_r;
    rx_wp_nxt  = rx_wp_r;
    rx_rp_nxt  = rx_rp_r;
    if (rx_push) begin
      rx_mem_nxt[rx_wp_r] = i_rx_pin.data;
      rx_wp_nxt           = rx_wp_r + 6'h01;
    end
    if (rx_pop) begin
      rx_rp_nxt = rx_rp_r + 6'h01;
    end
    rx_cnt_nxt = rx_cnt_r + 7'(rx_push) - 7'(rx_pop);
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rx_mem_r <= '{default: 32'h0000_0000};
      rx_wp_r  <= 6'h00;
      rx_rp_r  <= 6'h00;
      rx_cnt_r <= 7'h00;
    end else begin
      rx_mem_r <= rx_mem_nxt;
      rx_wp_r  <= rx_wp_nxt;
      rx_rp_r  <= rx_rp_nxt;
      rx_cnt_r <= rx_cnt_nxt;
    end
  end

  // Decouples the DMA's ready from the FIFO read path
  two_entry_buffer rx_out_buf (
    .i_clk       (i_clk),
    .i_rst       (i_rst),
    .i_in_valid  (rx_cnt_r != audio_fifo_pkg::FIFO_NONE),
    .i_in_data   (rx_mem_r[rx_rp_r]),
    .o_in_ready  (buf_in_ready),
    .o_out_valid (o_rx_dma_valid),
    .o_out_data  (o_rx_dma_data),
    .i_out_ready (i_rx_dma_ready)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Transmit FIFO

  logic [31:0] tx_mem_r [audio_fifo_pkg::DEPTH];
  logic [31:0] tx_mem_nxt [audio_fifo_pkg::DEPTH];
  logic [5:0]  tx_wp_r, tx_wp_nxt;
  logic [5:0]  tx_rp_r, tx_rp_nxt;
  logic [6:0]  tx_cnt_nxt;
  logic [31:0] tx_out_r, tx_out_nxt;
  logic        tx_push;
  logic        tx_pull;

  assign o_tx_dma_ready = (tx_cnt_r != audio_fifo_pkg::FIFO_FULL);  // [RULE4]
  assign o_tx_pin_valid = (tx_cnt_r != audio_fifo_pkg::FIFO_NONE);
  assign o_tx_pin_data  = tx_out_r;
  assign tx_push        = i_tx_dma.valid & o_tx_dma_ready;
  assign tx_pull        = i_tx_pin_pull & o_tx_pin_valid;
  assign tx_underflow   = i_tx_pin_pull & ~o_tx_pin_valid;  // [RULE6]

  always_comb begin
    tx_mem_nxt = tx_mem_r;
    tx_wp_nxt  = tx_wp_r;
    tx_rp_nxt  = tx_rp_r;
    tx_out_nxt = tx_out_r;
    if (tx_push) begin
      tx_mem_nxt[tx_wp_r] = i_tx_dma.data;
      tx_wp_nxt           = tx_wp_r + 6'h01;
    end
    // On underflow the pin side keeps the last word
    if (tx_pull) begin
      tx_out_nxt = tx_mem_r[tx_rp_r];
      tx_rp_nxt  = tx_rp_r + 6'h01;
    end
    tx_cnt_nxt = tx_cnt_r + 7'(tx_push) - 7'(tx_pull);
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      tx_mem_r <= '{default: 32'h0000_0000};
      tx_wp_r  <= 6'h00;
      tx_rp_r  <= 6'h00;
      tx_cnt_r <= 7'h00;
      tx_out_r <= 32'h0000_0000;
    end else begin
      tx_mem_r <= tx_mem_nxt;
      tx_wp_r  <= tx_wp_nxt;
      tx_rp_r  <= tx_rp_nxt;
      tx_cnt_r <= tx_cnt_nxt;
      tx_out_r <= tx_out_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // DMA events

  logic [7:0] rx_pin_cnt_r, rx_dma_cnt_r, tx_pin_cnt_r, tx_dma_cnt_r;
  logic [7:0] rx_pend_r, rx_pend_nxt, tx_pend_r, tx_pend_nxt;
  logic [8:0] rx_pin_st, rx_dma_st, tx_pin_st, tx_dma_st;
  logic       rx_set, rx_clr, tx_set, tx_clr;

  always_comb begin
    rx_pin_st   = thr_step(rx_pin_cnt_r, rx_push, rx_thr);  // [RULE1]
    rx_dma_st   = thr_step(rx_dma_cnt_r, rx_take, rx_thr);  // [RULE2]
    tx_pin_st   = thr_step(tx_pin_cnt_r, tx_pull, tx_thr);  // [RULE1]
    tx_dma_st   = thr_step(tx_dma_cnt_r, tx_push, tx_thr);  // [RULE2]
    rx_set      = rx_pin_st[8];
    rx_clr      = rx_dma_st[8];
    // Enabling transmit asks for the first fill
    tx_set      = tx_pin_st[8] | tx_start;
    tx_clr      = tx_dma_st[8];
    rx_pend_nxt = pend_step(rx_pend_r, rx_set, rx_clr);  // [RULE5]
    tx_pend_nxt = pend_step(tx_pend_r, tx_set, tx_clr);  // [RULE5]
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rx_pin_cnt_r <= 8'h00;
      rx_dma_cnt_r <= 8'h00;
      tx_pin_cnt_r <= 8'h00;
      tx_dma_cnt_r <= 8'h00;
      rx_pend_r    <= 8'h00;
      tx_pend_r    <= 8'h00;
    end else begin
      rx_pin_cnt_r <= rx_pin_st[7:0];
      rx_dma_cnt_r <= rx_dma_st[7:0];
      tx_pin_cnt_r <= tx_pin_st[7:0];
      tx_dma_cnt_r <= tx_dma_st[7:0];
      rx_pend_r    <= rx_pend_nxt;
      tx_pend_r    <= tx_pend_nxt;
    end
  end

  assign o_rx_dma_event = (rx_pend_r != 8'h00);  // [RULE9]
  assign o_tx_dma_event = (tx_pend_r != 8'h00);  // [RULE9]

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  rx_evt_set_a: assert property ( // [RULE1]
    @(posedge i_clk) disable iff (i_rst)
    rx_set |=> o_rx_dma_event)
    else $error("rx event missing after threshold pin words");

  tx_evt_clr_a: assert property ( // [RULE2]
    @(posedge i_clk) disable iff (i_rst)
    (tx_clr && !tx_set && tx_pend_r == 8'h01) |=> !o_tx_dma_event)
    else $error("tx event not retired after threshold dma words");

  rx_thr_cnt_a: assert property ( // [RULE3]
    @(posedge i_clk) disable iff (i_rst)
    (rx_thr != 8'h00 && $stable(rx_thr)) |-> rx_pin_cnt_r < rx_thr)
    else $error("rx pin counter passed the threshold field");

  rx_depth_a: assert property ( // [RULE4]
    @(posedge i_clk) disable iff (i_rst)
    rx_cnt_r <= audio_fifo_pkg::FIFO_FULL)
    else $error("rx fifo level above depth");

  set_wins_a: assert property ( // [RULE5]
    @(posedge i_clk) disable iff (i_rst)
    (rx_set && rx_clr) |=> o_rx_dma_event ##0 (rx_pend_r == $past(rx_pend_r)
                                     || $past(rx_pend_r) == 8'h00))
    else $error("rx event lost on coinciding set and clear");

  rx_ovf_flag_a: assert property ( // [RULE6]
    @(posedge i_clk) disable iff (i_rst)
    (i_rx_pin.valid && rx_ctl_r[audio_fifo_pkg::EN_BIT]
     && rx_cnt_r == audio_fifo_pkg::FIFO_FULL)
    |=> rx_ovf_r && rx_cnt_r != 7'h00)
    else $error("rx overflow not flagged");

  tx_udf_flag_a: assert property ( // [RULE6]
    @(posedge i_clk) disable iff (i_rst)
    (i_tx_pin_pull && tx_cnt_r == 7'h00) |=> tx_udf_r && $stable(tx_out_r))
    else $error("tx underflow not flagged");

  evt_level_a: assert property ( // [RULE9]
    @(posedge i_clk) disable iff (i_rst)
    (o_tx_dma_event && !tx_clr) |=> o_tx_dma_event)
    else $error("tx event dropped without a clear");

  bus_answer_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("bus answer later than one wait cycle");

endmodule : audio_port_fifo_dma_event

// ### dma_partner_model.sv
`timescale 1ns/100ps
module dma_partner_model (
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  // Receive stream
  input  wire logic             i_rx_valid,
  input  wire logic [31:0]      i_rx_data,
  output logic                  o_rx_ready,
  // Transmit stream
  output audio_fifo_pkg::word_t o_tx,
  input  wire logic             i_tx_ready,
  // Bench control
  input  wire logic [15:0]      i_rx_limit,
  input  wire logic             i_tx_go,
  input  wire logic [7:0]       i_tx_todo,
  output logic                  o_tx_busy
);
  logic [31:0] got_q[$];
  logic [15:0] got_n_r;
  logic [7:0]  left_r;
  logic [31:0] seq_r;
  // Takes at once while under budget; a zero budget models a stall
  assign o_rx_ready = (got_n_r < i_rx_limit);
  assign o_tx_busy  = o_tx.valid;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      got_n_r <= 16'h0000;
      left_r  <= 8'h00;
      seq_r   <= 32'h0000_a000;
      o_tx    <= '0;
    end else begin
      if (i_rx_valid && o_rx_ready) begin
        got_q.push_back(i_rx_data);
        got_n_r <= got_n_r + 16'h0001;
      end
      if (i_tx_go) begin
        left_r <= i_tx_todo;
        o_tx   <= '{valid: 1'b1, data: seq_r};
      end else if (o_tx.valid && i_tx_ready) begin
        seq_r      <= seq_r + 32'h0000_0001;
        left_r     <= left_r - 8'h01;
        o_tx.valid <= (left_r != 8'h01);
        // Idle data inverts so a stale word is never mistaken for a live one
        o_tx.data  <= (left_r != 8'h01) ? seq_r + 32'h0000_0001 : ~seq_r;
      end
    end
  end
endmodule : dma_partner_model

// ### audio_port_fifo_dma_event_tb_top.sv
`timescale 1ns/100ps
module audio_port_fifo_dma_event_tb_top;
  logic                     clk, rst, tx_pull, tx_go, tx_busy;
  audio_fifo_pkg::avs_req_t avs;
  audio_fifo_pkg::word_t    rx_pin, tx_word;
  logic [31:0]              rdata, rd, rx_dma_data, tx_pin_data;
  logic                     waitreq, rx_dma_valid, rx_dma_ready, rx_evt;
  logic                     tx_ready, tx_evt, tx_pin_valid;
  logic [15:0]              rx_limit;
  logic [7:0]               tx_todo;
  int                       mismatches, checks_done;
  ////////////////////////////////////////////////////////////////////////
  audio_port_fifo_dma_event u_dut (
    .i_clk(clk), .i_rst(rst), .i_avs(avs), .o_avs_readdata(rdata),
    .o_avs_waitrequest(waitreq), .i_rx_pin(rx_pin),
    .o_rx_dma_valid(rx_dma_valid), .o_rx_dma_data(rx_dma_data),
    .i_rx_dma_ready(rx_dma_ready), .o_rx_dma_event(rx_evt),
    .i_tx_dma(tx_word), .o_tx_dma_ready(tx_ready), .o_tx_dma_event(tx_evt),
    .i_tx_pin_pull(tx_pull), .o_tx_pin_data(tx_pin_data),
    .o_tx_pin_valid(tx_pin_valid));
  dma_partner_model u_dma (
    .i_clk(clk), .i_rst(rst), .i_rx_valid(rx_dma_valid),
    .i_rx_data(rx_dma_data), .o_rx_ready(rx_dma_ready), .o_tx(tx_word),
    .i_tx_ready(tx_ready), .i_rx_limit(rx_limit), .i_tx_go(tx_go),
    .i_tx_todo(tx_todo), .o_tx_busy(tx_busy));
  always #2.5 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    $display("Checks %0d, mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk32
  task automatic chk1(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t: flag %b expected %b", $time, got, exp);
    end
  endtask : chk1
  // Waits on waitrequest as the edge sees it, so no fixed latency is assumed
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] d, input logic [3:0] be);
    logic w;
    int   n;
    n = 0;
    @(posedge clk);
    avs <= '{read: ~wr, write: wr, address: a, writedata: d, byteenable: be};
    do begin
      @(negedge clk);
      w  = waitreq;
      rd = rdata;
      @(posedge clk);
      n++;
    end while (w !== 1'b0 && n < 50);
    if (w !== 1'b0) chk1(w, 1'b0);
    avs <= '0;
  endtask : bus
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000, 4'h0);
    chk32(rd, exp);
  endtask : rd_chk
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic lim(input logic [15:0] v);
    @(posedge clk);
    rx_limit <= v;
  endtask : lim
  task automatic push(input int n, input logic [31:0] base);
    @(posedge clk);
    for (int k = 0; k < n; k++) begin
      rx_pin <= '{valid: 1'b1, data: base + 32'(k)};
      @(posedge clk);
    end
    rx_pin <= '{valid: 1'b0, data: ~base};
  endtask : push
  task automatic pull(input int n, input logic [31:0] base);
    for (int k = 0; k < n; k++) begin
      @(posedge clk);
      tx_pull <= 1'b1;
      @(posedge clk);
      tx_pull <= 1'b0;
      @(negedge clk);
      chk32(tx_pin_data, base + 32'(k));
    end
  endtask : pull
  task automatic tx_send(input logic [7:0] n);
    @(posedge clk);
    tx_todo <= n;
    tx_go   <= 1'b1;
    @(posedge clk);
    tx_go   <= 1'b0;
    repeat (300) begin
      @(negedge clk);
      if (!tx_busy) break;
    end
  endtask : tx_send
  task automatic got_chk(input int first, input int n, input logic [31:0] b);
    for (int k = 0; k < n; k++)
      chk32(u_dma.got_q[first + k], b + 32'(k));
  endtask : got_chk
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    $display("ERROR %0t: watchdog expired", $time);
    wrap_up();
  end
  initial begin
    clk         = 1'b0;
    rst         = 1'b1;
    avs         = '0;
    rx_pin      = '0;
    tx_pull     = 1'b0;
    tx_go       = 1'b0;
    tx_todo     = 8'h00;
    rx_limit    = 16'h0000;
    mismatches  = 0;
    checks_done = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rd_chk(audio_fifo_pkg::RX_CTL_OFS, audio_fifo_pkg::CTL_RESET);
    rd_chk(audio_fifo_pkg::TX_CTL_OFS, audio_fifo_pkg::CTL_RESET);
    rd_chk(audio_fifo_pkg::STATUS_OFS, 32'h0000_0000);
    bus(1'b1, 4'hc, 32'hffff_ffff, 4'hf);
    rd_chk(4'hc, 32'h0000_0000);
    rd_chk(audio_fifo_pkg::RX_CTL_OFS, audio_fifo_pkg::CTL_RESET);
    $display("Test reset and registers done");
    // Threshold 4: a serializer multiple below 32
    bus(1'b1, audio_fifo_pkg::RX_CTL_OFS, 32'h0001_0400, 4'hf);
    rd_chk(audio_fifo_pkg::RX_CTL_OFS, 32'h0001_0400);
    push(3, 32'h0000_1000);
    cyc(2);
    chk1(rx_evt, 1'b0);
    push(1, 32'h0000_1003);
    cyc(2);
    chk1(rx_evt, 1'b1);
    cyc(10);
    chk1(rx_evt, 1'b1);
    push(4, 32'h0000_1004);
    lim(16'd4);
    cyc(20);
    chk1(rx_evt, 1'b1);
    lim(16'd8);
    cyc(20);
    chk1(rx_evt, 1'b0);
    // Fourth take lands on the fourth pin word of the next batch
    push(4, 32'h0000_1008);
    cyc(4);
    // Same launch edge, so set and clear meet in one cycle
    fork
      lim(16'd12);
      push(4, 32'h0000_100c);
    join
    cyc(20);
    chk1(rx_evt, 1'b1);
    lim(16'd16);
    cyc(20);
    chk1(rx_evt, 1'b0);
    got_chk(0, 16, 32'h0000_1000);
    $display("Test receive events done");
    push(68, 32'h0000_2000);
    cyc(2);
    rd_chk(audio_fifo_pkg::STATUS_OFS, 32'h0000_4005);
    bus(1'b1, audio_fifo_pkg::STATUS_OFS, 32'h0000_0001, 4'h1);
    rd_chk(audio_fifo_pkg::STATUS_OFS, 32'h0000_4004);
    lim(16'd82);
    cyc(200);
    chk1(rx_dma_valid, 1'b0);
    chk1(rx_evt, 1'b0);
    chk32(32'(u_dma.got_q.size()), 32'd82);
    got_chk(16, 66, 32'h0000_2000);
    $display("Test receive overflow done");
    chk1(tx_ready, 1'b1);
    bus(1'b1, audio_fifo_pkg::TX_CTL_OFS, 32'h0001_0400, 4'hf);
    cyc(2);
    chk1(tx_evt, 1'b1);
    tx_send(8'd4);
    cyc(2);
    chk1(tx_evt, 1'b0);
    tx_send(8'd60);
    cyc(2);
    chk1(tx_ready, 1'b0);
    chk1(tx_evt, 1'b0);
    rd_chk(audio_fifo_pkg::STATUS_OFS, 32'h0040_0000);
    pull(4, 32'h0000_a000);
    cyc(2);
    chk1(tx_evt, 1'b1);
    pull(60, 32'h0000_a004);
    chk1(tx_pin_valid, 1'b0);
    pull(1, 32'h0000_a03f);
    rd_chk(audio_fifo_pkg::STATUS_OFS, 32'h0000_000a);
    bus(1'b1, audio_fifo_pkg::STATUS_OFS, 32'h0000_0002, 4'h1);
    rd_chk(audio_fifo_pkg::STATUS_OFS, 32'h0000_0008);
    $display("Test transmit path done");
    wrap_up();
  end
endmodule : audio_port_fifo_dma_event_tb_top
